/* File: rtl/post_reporter_regs.vh */
// Constants for the power-on self-test reporter: error codes, test count, switch setting and timing.
`ifndef POST_REPORTER_REGS_VH
`define POST_REPORTER_REGS_VH
`define CODE_STACK_MEM 7'h3D
`define CODE_PROG_CSUM 7'h3E
`define CODE_WORK_MEM 7'h40
`define CODE_ANALOG_PIA 7'h41
`define CODE_KEYDISP_PIA 7'h42
`define CODE_ADC 7'h43
`define CODE_BUS_IF 7'h44
`define CODE_TIMER 7'h45
`define CODE_KD_CTRL 7'h46
`define CODE_KEY_DATA 7'h47
`define CODE_KEY_LINE 7'h48
`define CODE_KD_SELFTEST 7'h49
`define CODE_DISP_DEAD 7'h4A
`define CODE_ANALOG_DATA 7'h4B
`define NUM_TESTS 14
`define SW_ALL_ERRORS 7'h48
`define CLK_HZ 40000000
`define BLINK_HZ 4
`define BLINK_HALF_CYCLES (`CLK_HZ / (2 * `BLINK_HZ))
`define SHOW_MS 1000
`define SHOW_CYCLES (`CLK_HZ / 1000 * `SHOW_MS)
`endif

/* File: rtl/power_on_self_test_reporter.v */
// Power-on self-test sequencer and reporter for display and service LEDs.
`timescale 1ns/1ps
`default_nettype none
`include "post_reporter_regs.vh"
module power_on_self_test_reporter #(
    parameter integer BLINK_HALF = `BLINK_HALF_CYCLES,
    parameter integer SHOW_TIME = `SHOW_CYCLES
) (
    // Clock, reset and clock enable.
    input wire I_CORE_CLK,
    input wire I_RST,
    input wire I_CLK_EN,
    // Power switch, high at on, low at standby_position.
    input wire I_POWER_ON,
    // Service config switch bank, bit 0 is switch one.
    input wire [6:0] I_SERVICE_CONFIG_SWITCH_BANK,
    // Test results in fixed order 61, 62, 64..75 (bit 0 = code 61); high means failed.
    // Code 63 has no test, so there are fourteen result lines.
    input wire [13:0] I_TEST_FAIL,
    // Test engine handshake: start pulse, done level.
    output reg O_TEST_START,
    input wire I_TEST_DONE,
    // Display outputs.
    output reg O_DISP_PASS,
    output reg O_DISP_CODE_VALID,
    output reg [6:0] O_DISP_CODE,
    output reg O_REPORT_ALL,
    output reg O_NORMAL_RUN,
    // Service LEDs, bit 7 is LED one, bit 6 LED two (code MSB).
    output reg [7:0] O_SERVICE_LED
);
    localparam [2:0] ST_OFF = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_SCAN = 3'h3;
    localparam [2:0] ST_SHOW = 3'h4;
    localparam [2:0] ST_PASS = 3'h5;
    localparam [2:0] ST_RUN = 3'h6;

    // Two-stage synchronisers for pin inputs.
    reg [22:0] sync1_reg;
    reg [22:0] sync2_reg;
    wire pwr = sync2_reg[0];
    wire done = sync2_reg[1];
    wire [6:0] sw = sync2_reg[8:2];
    wire [13:0] fails = sync2_reg[22:9];

    reg [2:0] state_reg;
    reg pwr_d_reg;
    reg [13:0] fail_reg;
    reg [3:0] idx_reg;
    reg all_reg;
    reg [31:0] show_cnt_reg;
    reg [31:0] blink_cnt_reg;
    reg blink_reg;

    // Map test index to its code; code 63 has no test, so later indices are offset by one.
    function [6:0] code_of;
        input [3:0] idx;
        begin
            if (idx < 4'h2)
            begin
                code_of = `CODE_STACK_MEM + {3'h0, idx};
            end
            else
            begin
                code_of = `CODE_WORK_MEM + {3'h0, idx} - 7'h02;
            end
        end
    endfunction

    // Synchronise the power, done, switch and fail inputs before use.
    always @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            sync1_reg <= 23'h00_0000;
            sync2_reg <= 23'h00_0000;
        end
        else if (I_CLK_EN)
        begin
            sync1_reg <= {I_TEST_FAIL, I_SERVICE_CONFIG_SWITCH_BANK, I_TEST_DONE, I_POWER_ON};
            sync2_reg <= sync1_reg;
        end
    end

    // Blink divider runs free; only shown while a code is reported.
    always @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            blink_cnt_reg <= 32'h0000_0000;
            blink_reg <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            if (blink_cnt_reg >= BLINK_HALF - 1)
            begin
                blink_cnt_reg <= 32'h0000_0000;
                blink_reg <= ~blink_reg;
            end
            else
            begin
                blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // Main sequencer. A dropped power switch always returns to off.
    always @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            state_reg <= ST_OFF;
            pwr_d_reg <= 1'b0;
            fail_reg <= 14'h0000;
            idx_reg <= 4'h0;
            all_reg <= 1'b0;
            show_cnt_reg <= 32'h0000_0000;
            O_TEST_START <= 1'b0;
            O_DISP_PASS <= 1'b0;
            O_DISP_CODE_VALID <= 1'b0;
            O_DISP_CODE <= 7'h00;
            O_REPORT_ALL <= 1'b0;
            O_NORMAL_RUN <= 1'b0;
            O_SERVICE_LED <= 8'h00;
        end
        else if (I_CLK_EN)
        begin
            pwr_d_reg <= pwr;
            O_TEST_START <= 1'b0;
            // LED one follows the blink only while a code stands.
            O_SERVICE_LED[7] <= (state_reg == ST_SHOW) ? blink_reg : 1'b0;
            if (!pwr)
            begin
                // Standby clears the report so the next power-on starts fresh.
                state_reg <= ST_OFF;
                O_DISP_PASS <= 1'b0;
                O_DISP_CODE_VALID <= 1'b0;
                O_NORMAL_RUN <= 1'b0;
                O_SERVICE_LED <= 8'h00;
            end
            else
            begin
                case (state_reg)
                    ST_OFF:
                    begin
                        if (!pwr_d_reg)
                        begin
                            // Switches are caught at the power-on edge only.
                            all_reg <= (sw == `SW_ALL_ERRORS);
                            O_REPORT_ALL <= (sw == `SW_ALL_ERRORS);
                            state_reg <= ST_START;
                        end
                    end
                    ST_START:
                    begin
                        O_TEST_START <= 1'b1;
                        state_reg <= ST_WAIT;
                    end
                    ST_WAIT:
                    begin
                        // Take the results once done is high and the start pulse has ended.
                        if (done && !O_TEST_START)
                        begin
                            fail_reg <= fails;
                            idx_reg <= 4'h0;
                            state_reg <= ST_SCAN;
                        end
                    end
                    ST_SCAN:
                    begin
                        if (fail_reg == 14'h0000)
                        begin
                            O_DISP_PASS <= 1'b1;
                            state_reg <= ST_PASS;
                        end
                        else if (fail_reg[idx_reg])
                        begin
                            O_DISP_CODE <= code_of(idx_reg);
                            O_DISP_CODE_VALID <= 1'b1;
                            O_SERVICE_LED[6:0] <= code_of(idx_reg);
                            show_cnt_reg <= 32'h0000_0000;
                            state_reg <= ST_SHOW;
                        end
                        else
                        begin
                            idx_reg <= (idx_reg == `NUM_TESTS - 1) ? 4'h0 : idx_reg + 4'h1;
                        end
                    end
                    ST_SHOW:
                    begin
                        if (show_cnt_reg >= SHOW_TIME - 1)
                        begin
                            // Without report-all only the first failure is repeated.
                            if (all_reg)
                            begin
                                fail_reg <= fail_reg;
                                idx_reg <= (idx_reg == `NUM_TESTS - 1) ? 4'h0 : idx_reg + 4'h1;
                                O_DISP_CODE_VALID <= 1'b0;
                                state_reg <= ST_SCAN;
                            end
                            show_cnt_reg <= 32'h0000_0000;
                        end
                        else
                        begin
                            show_cnt_reg <= show_cnt_reg + 32'h0000_0001;
                        end
                    end
                    ST_PASS:
                    begin
                        O_NORMAL_RUN <= 1'b1;
                        state_reg <= ST_RUN;
                    end
                    ST_RUN:
                    begin
                        state_reg <= ST_RUN;
                    end
                    default:
                    begin
                        state_reg <= ST_OFF;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/post_reporter_properties.sv */
// Checker that ties the reporter's outputs to its inputs.
`timescale 1ns/1ps
`default_nettype none
module post_reporter_props #(
    parameter integer BLINK_HALF = 4
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_CLK_EN,
    input wire logic I_POWER_ON,
    input wire logic [6:0] I_SERVICE_CONFIG_SWITCH_BANK,
    input wire logic O_TEST_START,
    input wire logic O_DISP_PASS,
    input wire logic O_DISP_CODE_VALID,
    input wire logic [6:0] O_DISP_CODE,
    input wire logic O_REPORT_ALL,
    input wire logic O_NORMAL_RUN,
    input wire logic [7:0] O_SERVICE_LED
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    // A frozen clock enable holds every output, so timing checks rest while it is low.
    default disable iff (I_RST || !I_CLK_EN);
    led_code_a: assert property (O_DISP_CODE_VALID |-> O_SERVICE_LED[6:0] == O_DISP_CODE)
        else $error("LED code differs from shown code");
    code_range_a: assert property (O_DISP_CODE_VALID |-> O_DISP_CODE inside {[7'h3D:7'h3E], [7'h40:7'h4B]})
        else $error("Shown code outside the code set");
    pass_excl_a: assert property (O_DISP_CODE_VALID |-> !O_DISP_PASS && !O_NORMAL_RUN)
        else $error("Pass shown together with a code");
    start_pulse_a: assert property (O_TEST_START |=> !O_TEST_START)
        else $error("Test start longer than one cycle");
    // Sync delay of two flops plus one cycle to clear.
    power_off_a: assert property (!I_POWER_ON [*4] |=> !O_DISP_PASS && !O_DISP_CODE_VALID)
        else $error("Outputs not cleared at standby");
    // LED one trails the blink by a cycle and is forced low on the first shown cycle,
    // so six shown cycles are needed before it differs from its value a half period back.
    blink_a: assert property (O_DISP_CODE_VALID [*6] |-> O_SERVICE_LED[7] != $past(O_SERVICE_LED[7], BLINK_HALF))
        else $error("LED one not blinking");
    report_all_a: assert property (O_TEST_START |-> O_REPORT_ALL == (I_SERVICE_CONFIG_SWITCH_BANK == 7'h48))
        else $error("Report mode does not match switches");
    code_hold_a: assert property (O_DISP_CODE_VALID && !O_REPORT_ALL |=> !O_DISP_CODE_VALID || $stable(O_DISP_CODE))
        else $error("Single code mode changed the code");
    cover property (O_DISP_PASS);
    cover property (O_REPORT_ALL && O_DISP_CODE_VALID);
    cover property ($rose(O_TEST_START));
endmodule
`default_nettype wire

/* File: test/post_test_engine_model.sv */
// Behavioural model of the board test engine that answers the reporter.
`timescale 1ns/1ps
`default_nettype none
module post_test_engine_model #(
    parameter integer LATENCY = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic power,
    input wire logic [13:0] fail_set,
    output logic done,
    output logic [13:0] fail
);
    integer cnt;
    // Results are only valid with done; before that the lines show garbage.
    assign fail = done ? fail_set : ~fail_set;
    // Answer a start after LATENCY cycles; standby drops the result.
    always @(posedge clk or posedge rst)
    begin
        if (rst || !power)
        begin
            cnt <= 0;
            done <= 1'b0;
        end
        else if (start)
            cnt <= LATENCY;
        else if (cnt == 1)
        begin
            cnt <= 0;
            done <= 1'b1;
        end
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the power-on self-test reporter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
    logic clk = 0, rst = 1, pwr = 0, en = 1, done;
    logic [6:0] sw = 7'h00;
    logic [13:0] fset = 14'h0000, fail;
    wire start, pass, valid, rall, run;
    wire [6:0] code;
    wire [7:0] led;
    integer num_errors = 0, checks_done = 0;
    initial forever #12.5 clk = ~clk;
    power_on_self_test_reporter #(.BLINK_HALF(4), .SHOW_TIME(8)) dut (.I_CORE_CLK(clk),
        .I_RST(rst), .I_CLK_EN(en), .I_POWER_ON(pwr), .I_SERVICE_CONFIG_SWITCH_BANK(sw),
        .I_TEST_FAIL(fail), .O_TEST_START(start), .I_TEST_DONE(done), .O_DISP_PASS(pass),
        .O_DISP_CODE_VALID(valid), .O_DISP_CODE(code), .O_REPORT_ALL(rall),
        .O_NORMAL_RUN(run), .O_SERVICE_LED(led));
    post_test_engine_model eng (.clk(clk), .rst(rst), .start(start), .power(pwr),
        .fail_set(fset), .done(done), .fail(fail));
    task automatic cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // Power cycle with the given switches and failures, then wait for a verdict.
    task automatic boot(input logic [6:0] s, input logic [13:0] f);
        pwr = 0;
        cyc(6);
        sw = s;
        fset = f;
        cyc(4);
        pwr = 1;
        for (int i = 0; i < 20 && start !== 1'b1; i++) cyc(1);
        `CHK("start", 1'b1, start)
        for (int i = 0; i < 60 && pass !== 1'b1 && valid !== 1'b1; i++) cyc(1);
        cyc(2);
    endtask
    task automatic t_pass;
        boot(7'h00, 15'h0000);
        `CHK("pass", 1'b1, pass)
        `CHK("run", 1'b1, run)
        `CHK("valid", 1'b0, valid)
    endtask
    // Switch one also on, so only the first failure is held.
    task automatic t_single;
        logic b;
        boot(7'h49, 14'h2004);
        `CHK("rall", 1'b0, rall)
        b = led[7];
        cyc(4);
        `CHK("blink", ~b, led[7])
        cyc(30);
        `CHK("code", 7'h40, code)
        `CHK("led", 7'h40, led[6:0])
        // Clock enable low freezes all state, so LED one must hold for a half period.
        en = 0;
        b = led[7];
        cyc(4);
        `CHK("freeze", b, led[7])
        en = 1;
    endtask
    // Every failure shown in index order, twice round.
    task automatic t_all;
        // Failing tests 61, 62, 65, 66, 70 and 75, in the order they must appear.
        logic [6:0] q[6] = '{7'd61, 7'd62, 7'd65, 7'd66, 7'd70, 7'd75};
        boot(7'h48, 14'h211B);
        `CHK("rall", 1'b1, rall)
        for (int j = 0; j < 12; j++)
        begin
            if (j > 0)
            begin
                for (int i = 0; i < 40 && valid !== 1'b0; i++) cyc(1);
                for (int i = 0; i < 40 && valid !== 1'b1; i++) cyc(1);
            end
            `CHK("seq", q[j % 6], code)
        end
    endtask
    task automatic t_off;
        pwr = 0;
        cyc(5);
        `CHK("off", 3'b000, {pass, valid, run})
        `CHK("led off", 8'h00, led)
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        cyc(16);
        rst = 0;
        t_pass;
        t_single;
        t_all;
        t_off;
        t_pass;
        report_and_stop;
    end
    // Whole run needs about three hundred cycles.
    initial
    begin
        #100us;
        num_errors++;
        report_and_stop;
    end
endmodule
bind power_on_self_test_reporter post_reporter_props #(.BLINK_HALF(BLINK_HALF)) props (
    .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_CLK_EN(I_CLK_EN), .I_POWER_ON(I_POWER_ON),
    .I_SERVICE_CONFIG_SWITCH_BANK(I_SERVICE_CONFIG_SWITCH_BANK), .O_TEST_START(O_TEST_START),
    .O_DISP_PASS(O_DISP_PASS), .O_DISP_CODE_VALID(O_DISP_CODE_VALID), .O_DISP_CODE(O_DISP_CODE),
    .O_REPORT_ALL(O_REPORT_ALL), .O_NORMAL_RUN(O_NORMAL_RUN), .O_SERVICE_LED(O_SERVICE_LED));
`default_nettype wire
